// File: design/load_spec_tracker.sv
/*
 * Load speculation tracker: advanced-load address table, general-register
 * deferred-token bits, token collection register, and the check logic.
 * Assumes one request per cycle in program order, a store port from the
 * memory path on the same clock, and a register file that applies resp_o.
 */
// Design decisions made here: the register offsets and the strobed register port.
// Function
// - advanced load allocates a table entry
// - entry keyed by register, holds address/type/size
// - check hit on register and type: proceed
// - advanced check miss branches to recovery
// - reload check miss reissues the load
// - overlapping store invalidates the entry
// - new advanced load replaces same-register entry
// - entries may drop for capacity reasons
// - each general register carries token bit
// - floating registers use special deferred value
// - deferred speculative load sets destination token
// - speculative ops propagate source tokens
// - non-speculative token read raises fault
// - speculation check on token branches
// - spill writes quadword, token to collection
// - fill loads quadword, token from collection
// - floating spill/fill never faults on token
// - speculative advanced load: no entry if deferred
// - full table evicts an entry for new
`timescale 1ns/100ps
`default_nettype none
`include "spec_track_defines.svh"

module load_spec_tracker
    import spec_track_pkg::*;
#(
    parameter int ENTRIES = `TABLE_ENTRIES,
    parameter int NUM_GR = `NUM_GR,
    // Arbitrary pattern; the floating unit's own token encoding goes here
    parameter logic [`FP_W-1:0] FP_TOKEN_VALUE = {2'h1, 80'h0}
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Instruction stream
    input wire req_t req_i,
    // Store path
    input wire store_t store_i,
    // Register port
    input wire logic [`REG_ADDR_W-1:0] reg_addr,
    input wire logic [`REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`REG_DATA_W-1:0] reg_rdata,
    // Results towards the register files and fetch
    output resp_t resp_o,
    output logic token_o,
    output logic [`FP_W-1:0] fp_wdata
);

    localparam int PTR_W = $clog2(ENTRIES);

    typedef struct packed {
        entry_t [ENTRIES-1:0] ent;
        logic [NUM_GR-1:0] tok;
        logic [`COLL_W-1:0] coll;
        logic enable;
        logic [PTR_W-1:0] victim;
        resp_t resp;
        logic token;
        logic [`REG_DATA_W-1:0] rdata;
    } state_t;

    state_t q;
    state_t d;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte ranges [a, a+sa) and [b, b+sb) share at least one byte
    function automatic logic overlaps(
        input logic [`ADDR_W-1:0] a, input logic [`SIZE_W-1:0] sa,
        input logic [`ADDR_W-1:0] b, input logic [`SIZE_W-1:0] sb);
        logic [`ADDR_W:0] a_end;
        logic [`ADDR_W:0] b_end;
        a_end = {1'b0, a} + {{(`ADDR_W+1-`SIZE_W){1'b0}}, sa};
        b_end = {1'b0, b} + {{(`ADDR_W+1-`SIZE_W){1'b0}}, sb};
        return ({1'b0, a} < b_end) && ({1'b0, b} < a_end);
    endfunction

    // Table holds a live entry for this register and load type
    function automatic logic table_hit(
        input entry_t [ENTRIES-1:0] ent,
        input logic [`REG_IDX_W-1:0] r,
        input logic [`LOAD_TYPE_W-1:0] t);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < ENTRIES; i++)
        begin
            if (ent[i].valid && ent[i].reg_no == r && ent[i].ld_type == t)
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Any live entry overlaps the byte range
    function automatic logic range_held(
        input entry_t [ENTRIES-1:0] ent,
        input logic [`ADDR_W-1:0] a, input logic [`SIZE_W-1:0] s);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < ENTRIES; i++)
        begin
            if (ent[i].valid && overlaps(ent[i].addr, ent[i].size, a, s))
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state

    logic src_tok;
    logic [5:0] coll_sel;
    logic free_found;
    logic [PTR_W-1:0] free_idx;
    logic [PTR_W-1:0] slot;
    logic do_alloc;

    assign coll_sel = req_i.addr[`COLL_SEL_HI:`COLL_SEL_LO];

    always_comb
    begin
        d = q;
        d.resp = '0;
        d.token = 1'b0;
        d.rdata = '0;
        do_alloc = 1'b0;
        free_found = 1'b0;
        free_idx = '0;
        slot = '0;
        src_tok = (req_i.src_use[0] && q.tok[req_i.src1]) ||
                  (req_i.src_use[1] && q.tok[req_i.src2]);

        if (store_i.valid)
        begin
            for (int i = 0; i < ENTRIES; i++)
            begin
                if (q.ent[i].valid &&
                    overlaps(q.ent[i].addr, q.ent[i].size,
                             store_i.addr, store_i.size))
                begin
                    d.ent[i].valid = 1'b0;
                end
            end
        end

        // Register port
        if (reg_wr)
        begin
            unique case (reg_addr)
                `OFS_COLLECT: d.coll = reg_wdata;
                `OFS_CTRL:
                begin
                    d.enable = reg_wdata[`CTRL_ENABLE_BIT];
                    if (reg_wdata[`CTRL_FLUSH_BIT])
                    begin
                        for (int i = 0; i < ENTRIES; i++)
                        begin
                            d.ent[i].valid = 1'b0;
                        end
                    end
                end
                default: ;
            endcase
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                `OFS_COLLECT: d.rdata = q.coll;
                `OFS_CTRL: d.rdata[`CTRL_ENABLE_BIT] = q.enable;
                `OFS_STATUS:
                begin
                    for (int i = 0; i < ENTRIES; i++)
                    begin
                        d.rdata[i] = q.ent[i].valid;
                    end
                end
                default: d.rdata = '0;
            endcase
        end

        if (req_i.valid)
        begin
            d.resp.done = 1'b1;
            d.resp.proceed = 1'b1;
            d.resp.reg_no = req_i.dst;
            d.resp.mem_addr = req_i.addr;
            d.resp.mem_bytes = req_i.size;
            unique case (req_i.op)
                OP_ADVANCED_LOAD:
                begin
                    do_alloc = q.enable;
                    d.tok[req_i.dst] = 1'b0;
                end
                OP_SPEC_ADVANCED_LOAD:
                begin
                    // both actions, no entry when deferred
                    do_alloc = q.enable && !req_i.defer_exc;
                    d.tok[req_i.dst] = req_i.defer_exc;
                end
                OP_CONTROL_SPEC_LOAD:
                begin
                    d.tok[req_i.dst] = req_i.defer_exc;
                end
                OP_FP_SPEC_LOAD:
                begin
                    // floating token is a data value
                    d.resp.fp_token_we = req_i.defer_exc;
                end
                OP_CHECK_ADVANCED:
                begin
                    if (!table_hit(q.ent, req_i.dst, req_i.ld_type))
                    begin
                        d.resp.proceed = 1'b0;
                        d.resp.branch = 1'b1;
                        d.resp.target = req_i.recovery;
                    end
                end
                OP_CHECK_RELOAD:
                begin
                    if (!table_hit(q.ent, req_i.dst, req_i.ld_type))
                    begin
                        d.resp.reload = 1'b1;
                        d.tok[req_i.dst] = 1'b0;
                    end
                end
                OP_SPEC_CHECK:
                begin
                    if (q.tok[req_i.dst])
                    begin
                        d.resp.proceed = 1'b0;
                        d.resp.branch = 1'b1;
                        d.resp.target = req_i.recovery;
                    end
                end
                OP_ALU_SPEC:
                begin
                    if (req_i.dst_we)
                    begin
                        d.tok[req_i.dst] = src_tok;
                    end
                end
                OP_ALU_NONSPEC:
                begin
                    if (src_tok)
                    begin
                        d.resp.proceed = 1'b0;
                        d.resp.fault = 1'b1;
                    end
                    else if (req_i.dst_we)
                    begin
                        d.tok[req_i.dst] = 1'b0;
                    end
                end
                OP_GR_SPILL_STORE:
                begin
                    d.resp.mem_bytes = `SPILL_BYTES;
                    d.resp.reg_no = req_i.src1;
                    d.coll[coll_sel] = q.tok[req_i.src1];
                end
                OP_GR_FILL_LOAD:
                begin
                    d.resp.mem_bytes = `SPILL_BYTES;
                    d.tok[req_i.dst] = q.coll[coll_sel];
                end
                OP_FP_SPILL, OP_FP_FILL: ;
                default: ;
            endcase
            d.token = d.tok[req_i.dst];
        end

        // drop older entry of same register
        // Even with no allocation, so a later check cannot hit a stale entry
        if (req_i.valid && (req_i.op == OP_ADVANCED_LOAD ||
                            req_i.op == OP_SPEC_ADVANCED_LOAD))
        begin
            for (int i = 0; i < ENTRIES; i++)
            begin
                if (q.ent[i].reg_no == req_i.dst)
                begin
                    d.ent[i].valid = 1'b0;
                end
            end
        end
        if (do_alloc)
        begin
            for (int i = ENTRIES - 1; i >= 0; i--)
            begin
                if (!d.ent[i].valid)
                begin
                    free_found = 1'b1;
                    free_idx = PTR_W'(i);
                end
            end
            slot = free_found ? free_idx : q.victim;
            if (!free_found)
            begin
                d.victim = q.victim + PTR_W'(1);
            end
            d.ent[slot].valid = 1'b1;
            d.ent[slot].reg_no = req_i.dst;
            d.ent[slot].ld_type = req_i.ld_type;
            d.ent[slot].addr = req_i.addr;
            d.ent[slot].size = req_i.size;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            q <= '0;
            q.enable <= `CTRL_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign resp_o = q.resp;
    assign token_o = q.token;
    assign reg_rdata = q.rdata;
    assign fp_wdata = q.resp.fp_token_we ? FP_TOKEN_VALUE : '0;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_ALLOC: assert property (@(posedge mclk) disable iff (!rstn)
        req_i.valid && req_i.op == OP_ADVANCED_LOAD && q.enable &&
        !(reg_wr && reg_addr == `OFS_CTRL) |=>
        table_hit(q.ent, $past(req_i.dst), $past(req_i.ld_type)))
        else $error("advanced load left no entry");

    AST_CHK_HIT: assert property (@(posedge mclk) disable iff (!rstn)
        req_i.valid && req_i.op == OP_CHECK_ADVANCED &&
        table_hit(q.ent, req_i.dst, req_i.ld_type) |=>
        resp_o.proceed && !resp_o.branch)
        else $error("check hit did not proceed");

    AST_CHK_MISS: assert property (@(posedge mclk) disable iff (!rstn)
        req_i.valid && req_i.op == OP_CHECK_ADVANCED &&
        !table_hit(q.ent, req_i.dst, req_i.ld_type) |=>
        resp_o.branch && resp_o.target == $past(req_i.recovery))
        else $error("check miss did not branch");

    AST_RELOAD: assert property (@(posedge mclk) disable iff (!rstn)
        req_i.valid && req_i.op == OP_CHECK_RELOAD &&
        !table_hit(q.ent, req_i.dst, req_i.ld_type) |=>
        resp_o.reload && !resp_o.branch)
        else $error("reload check miss did not reissue");

    AST_STORE_INV: assert property (@(posedge mclk) disable iff (!rstn)
        store_i.valid && !req_i.valid |=>
        !range_held(q.ent, $past(store_i.addr), $past(store_i.size)))
        else $error("overlapped entry survived a store");

    AST_TOKEN_SET: assert property (@(posedge mclk) disable iff (!rstn)
        req_i.valid && req_i.op == OP_CONTROL_SPEC_LOAD && req_i.defer_exc
        |=> q.tok[$past(req_i.dst)] && token_o)
        else $error("deferred load token not set");

    AST_PROPAGATE: assert property (@(posedge mclk) disable iff (!rstn)
        req_i.valid && req_i.op == OP_ALU_SPEC && req_i.dst_we && src_tok
        |=> q.tok[$past(req_i.dst)])
        else $error("token not propagated");

    AST_FAULT: assert property (@(posedge mclk) disable iff (!rstn)
        req_i.valid && req_i.op == OP_ALU_NONSPEC && src_tok |=>
        resp_o.fault && !resp_o.proceed)
        else $error("token consumed without fault");

    AST_SPEC_CHECK: assert property (@(posedge mclk) disable iff (!rstn)
        req_i.valid && req_i.op == OP_SPEC_CHECK |=>
        resp_o.branch == $past(q.tok[req_i.dst]))
        else $error("speculation check branch wrong");

    AST_SPILL: assert property (@(posedge mclk) disable iff (!rstn)
        req_i.valid && req_i.op == OP_GR_SPILL_STORE && !reg_wr |=>
        q.coll[$past(coll_sel)] == $past(q.tok[req_i.src1]) &&
        resp_o.mem_bytes == `SPILL_BYTES)
        else $error("spill token not collected");

    AST_FILL: assert property (@(posedge mclk) disable iff (!rstn)
        req_i.valid && req_i.op == OP_GR_FILL_LOAD |=>
        q.tok[$past(req_i.dst)] == $past(q.coll[coll_sel]))
        else $error("fill token mismatch");

    AST_SA_DEFER: assert property (@(posedge mclk) disable iff (!rstn)
        req_i.valid && req_i.op == OP_SPEC_ADVANCED_LOAD && req_i.defer_exc
        |=> !table_hit(q.ent, $past(req_i.dst), $past(req_i.ld_type)) &&
        q.tok[$past(req_i.dst)])
        else $error("deferred speculative advanced load allocated");

    AST_FP_NOFAULT: assert property (@(posedge mclk) disable iff (!rstn)
        req_i.valid && (req_i.op == OP_FP_SPILL || req_i.op == OP_FP_FILL)
        |=> !resp_o.fault && resp_o.proceed)
        else $error("floating spill or fill faulted");

endmodule // load_spec_tracker

`default_nettype wire

// File: design/spec_track_defines.svh
/*
 * Constants of the load speculation tracker: widths, register offsets,
 * control fields and reset values.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef SPEC_TRACK_DEFINES_SVH
`define SPEC_TRACK_DEFINES_SVH

`define ADDR_W 64
`define REG_IDX_W 7
`define NUM_GR 128
`define TABLE_ENTRIES 8
`define LOAD_TYPE_W 2
`define SIZE_W 4
`define FP_W 82

// Spill store and fill load move a whole quadword
`define SPILL_BYTES 4'h8
// Address bits that pick a collection-register bit
`define COLL_SEL_HI 8
`define COLL_SEL_LO 3
`define COLL_W 64

// Register map (byte offsets on the plain register port)
`define REG_ADDR_W 8
`define REG_DATA_W 64
`define OFS_COLLECT 8'h00
`define OFS_CTRL 8'h08
`define OFS_STATUS 8'h10

// Control register fields
`define CTRL_ENABLE_BIT 0
`define CTRL_FLUSH_BIT 1
`define CTRL_RESET 1'b1

`endif

// File: design/spec_track_pkg.sv
/*
 * Types of the load speculation tracker: instruction kinds, request and
 * response carriers, table entry layout.
 * Assumes spec_track_defines.svh is on the include path.
 */
`include "spec_track_defines.svh"

package spec_track_pkg;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADVANCED_LOAD = 4'h1,
        OP_CHECK_ADVANCED = 4'h2,
        OP_CHECK_RELOAD = 4'h3,
        OP_CONTROL_SPEC_LOAD = 4'h4,
        OP_SPEC_ADVANCED_LOAD = 4'h5,
        OP_SPEC_CHECK = 4'h6,
        OP_ALU_SPEC = 4'h7,
        OP_ALU_NONSPEC = 4'h8,
        OP_GR_SPILL_STORE = 4'h9,
        OP_GR_FILL_LOAD = 4'ha,
        OP_FP_SPILL = 4'hb,
        OP_FP_FILL = 4'hc,
        OP_FP_SPEC_LOAD = 4'hd
    } op_t;

    typedef struct packed {
        logic valid;
        op_t op;
        logic [`REG_IDX_W-1:0] dst;
        logic dst_we;
        logic [`REG_IDX_W-1:0] src1;
        logic [`REG_IDX_W-1:0] src2;
        logic [1:0] src_use;
        logic [`ADDR_W-1:0] addr;
        logic [`SIZE_W-1:0] size;
        logic [`LOAD_TYPE_W-1:0] ld_type;
        logic defer_exc;
        logic [`ADDR_W-1:0] recovery;
    } req_t;

    typedef struct packed {
        logic valid;
        logic [`ADDR_W-1:0] addr;
        logic [`SIZE_W-1:0] size;
    } store_t;

    typedef struct packed {
        logic done;
        logic proceed;
        logic branch;
        logic reload;
        logic fault;
        logic fp_token_we;
        logic [`ADDR_W-1:0] target;
        logic [`REG_IDX_W-1:0] reg_no;
        logic [`ADDR_W-1:0] mem_addr;
        logic [`SIZE_W-1:0] mem_bytes;
    } resp_t;

    typedef struct packed {
        logic valid;
        logic [`REG_IDX_W-1:0] reg_no;
        logic [`LOAD_TYPE_W-1:0] ld_type;
        logic [`ADDR_W-1:0] addr;
        logic [`SIZE_W-1:0] size;
    } entry_t;

endpackage

// File: tb/store_path_model.sv
/*
 * Behavioural model of the memory store path feeding the tracker.
 * Assumes the bench calls put() from a process synchronous to mclk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "spec_track_defines.svh"

module store_path_model
    import spec_track_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Store path towards the tracker
    output var store_t store_o
);

    initial store_o = '0;

    task automatic put(input logic [`ADDR_W-1:0] a,
                       input logic [`SIZE_W-1:0] s);
        @(posedge mclk);
        store_o <= '{valid: 1'b1, addr: a, size: s};
        @(posedge mclk);
        // Idle lines must not look like a held address
        store_o <= '{valid: 1'b0, addr: ~a, size: ~s};
    endtask

endmodule // store_path_model
`default_nettype wire

// File: tb/load_spec_tracker_test.sv
/*
 * Self-checking bench for the load speculation tracker.
 * Assumes the package and defines header are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "spec_track_defines.svh"

module load_spec_tracker_test;
    import spec_track_pkg::*;

    localparam int N_ENT = 4;
    // Arbitrary pattern, distinct from the design default
    localparam logic [`FP_W-1:0] FP_TOK = {2'h2, 80'h5a};
    localparam logic [63:0] REC = 64'h4a00;

    logic mclk = 1'b0;
    logic rstn = 1'b0;
    req_t req = '0;
    store_t store_w;
    logic [`REG_ADDR_W-1:0] reg_addr = '0;
    logic [`REG_DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [`REG_DATA_W-1:0] reg_rdata;
    resp_t resp;
    logic token;
    logic [`FP_W-1:0] fp_wdata;
    logic [`REG_DATA_W-1:0] rd;
    int fail_count = 0;
    int n_compared = 0;

    always #12.5 mclk = ~mclk;

    load_spec_tracker #(
        .ENTRIES(N_ENT),
        .NUM_GR(`NUM_GR),
        .FP_TOKEN_VALUE(FP_TOK)
    ) load_spec_tracker_i (
        .mclk(mclk),
        .rstn(rstn),
        .req_i(req),
        .store_i(store_w),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .resp_o(resp),
        .token_o(token),
        .fp_wdata(fp_wdata)
    );

    store_path_model store_path_model_i (
        .mclk(mclk),
        .store_o(store_w)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [`FP_W-1:0] got,
                       input logic [`FP_W-1:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Expected {proceed, branch, reload, fault}, done always set
    task automatic rsp(input logic [3:0] e);
        chk({resp.done, resp.proceed, resp.branch, resp.reload, resp.fault},
            {1'b1, e});
    endtask

    task automatic issue(input op_t op, input logic [6:0] dst,
                         input logic [6:0] src, input logic [63:0] a,
                         input logic [1:0] typ, input logic dfr);
        @(posedge mclk);
        req <= '{valid: 1'b1, op: op, dst: dst, dst_we: 1'b1, src1: src,
                 src2: 7'h0, src_use: 2'h1, addr: a, size: 4'h8,
                 ld_type: typ, defer_exc: dfr, recovery: REC};
        @(posedge mclk);
        req <= '0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [63:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        // Far more than the sequence below needs
        #(25 * 5000);
        fail_count++;
        give_verdict();
    end

    initial
    begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        rdr(8'h08);
        chk(rd, 64'h1);
        rdr(8'h10);
        chk(rd, 64'h0);
        wr(8'h18, '1);
        rdr(8'h18);
        chk(rd, 64'h0);
        // Allocation, hit, type mismatch
        issue(OP_ADVANCED_LOAD, 7'd5, 7'd0, 64'h100, 2'h1, 1'b0);
        rdr(8'h10);
        chk(82'($countones(rd)), 82'h1);
        issue(OP_CHECK_ADVANCED, 7'd5, 7'd0, 64'h0, 2'h1, 1'b0);
        rsp(4'b1000);
        issue(OP_CHECK_ADVANCED, 7'd5, 7'd0, 64'h0, 2'h2, 1'b0);
        rsp(4'b0100);
        chk(resp.target, REC);
        // Store overlap by address and size
        store_path_model_i.put(64'h108, 4'h4);
        issue(OP_CHECK_RELOAD, 7'd5, 7'd0, 64'h100, 2'h1, 1'b0);
        rsp(4'b1000);
        store_path_model_i.put(64'h0ff, 4'h2);
        issue(OP_CHECK_RELOAD, 7'd5, 7'd0, 64'h100, 2'h1, 1'b0);
        rsp(4'b1010);
        chk({resp.reload, resp.mem_addr}, {1'b1, 64'h100});
        // Store inside the entry's range, away from its start
        issue(OP_ADVANCED_LOAD, 7'd5, 7'd0, 64'h100, 2'h1, 1'b0);
        store_path_model_i.put(64'h107, 4'h1);
        issue(OP_CHECK_RELOAD, 7'd5, 7'd0, 64'h100, 2'h1, 1'b0);
        rsp(4'b1010);
        // Same register replaces older entry
        issue(OP_ADVANCED_LOAD, 7'd6, 7'd0, 64'h200, 2'h1, 1'b0);
        issue(OP_ADVANCED_LOAD, 7'd6, 7'd0, 64'h300, 2'h1, 1'b0);
        rdr(8'h10);
        chk(82'($countones(rd)), 82'h1);
        store_path_model_i.put(64'h200, 4'h8);
        issue(OP_CHECK_ADVANCED, 7'd6, 7'd0, 64'h0, 2'h1, 1'b0);
        rsp(4'b1000);
        // Flush, then overfill the table
        wr(8'h08, 64'h3);
        rdr(8'h10);
        chk(rd, 64'h0);
        for (int i = 0; i <= N_ENT; i++)
            issue(OP_ADVANCED_LOAD, 7'(32 + i), 7'd0, 64'h1000 + 64'(i * 16),
                  2'h1, 1'b0);
        rdr(8'h10);
        chk(rd, 64'((1 << N_ENT) - 1));
        issue(OP_CHECK_ADVANCED, 7'(32 + N_ENT), 7'd0, 64'h0, 2'h1, 1'b0);
        rsp(4'b1000);
        // Allocation disabled
        wr(8'h08, 64'h2);
        issue(OP_ADVANCED_LOAD, 7'd40, 7'd0, 64'h500, 2'h1, 1'b0);
        rdr(8'h10);
        chk(rd, 64'h0);
        wr(8'h08, 64'h1);
        // Deferred tokens and their spread
        issue(OP_CONTROL_SPEC_LOAD, 7'd10, 7'd0, 64'h40, 2'h0, 1'b1);
        chk(token, 1'b1);
        issue(OP_ALU_SPEC, 7'd11, 7'd10, 64'h0, 2'h0, 1'b0);
        chk(token, 1'b1);
        issue(OP_CONTROL_SPEC_LOAD, 7'd12, 7'd0, 64'h48, 2'h0, 1'b0);
        chk(token, 1'b0);
        issue(OP_ALU_SPEC, 7'd14, 7'd12, 64'h0, 2'h0, 1'b0);
        chk(token, 1'b0);
        issue(OP_ALU_NONSPEC, 7'd15, 7'd11, 64'h0, 2'h0, 1'b0);
        rsp(4'b0001);
        issue(OP_SPEC_CHECK, 7'd11, 7'd0, 64'h0, 2'h0, 1'b0);
        chk({resp.branch, resp.target}, {1'b1, REC});
        issue(OP_SPEC_CHECK, 7'd12, 7'd0, 64'h0, 2'h0, 1'b0);
        chk(resp.branch, 1'b0);
        // Combined speculative advanced load; older entry must go too
        issue(OP_ADVANCED_LOAD, 7'd20, 7'd0, 64'h600, 2'h1, 1'b0);
        issue(OP_SPEC_ADVANCED_LOAD, 7'd20, 7'd0, 64'h600, 2'h1, 1'b1);
        chk(token, 1'b1);
        issue(OP_CHECK_ADVANCED, 7'd20, 7'd0, 64'h0, 2'h1, 1'b0);
        rsp(4'b0100);
        issue(OP_SPEC_ADVANCED_LOAD, 7'd21, 7'd0, 64'h700, 2'h1, 1'b0);
        issue(OP_CHECK_ADVANCED, 7'd21, 7'd0, 64'h0, 2'h1, 1'b0);
        rsp(4'b1000);
        // Spill and fill through the collection register
        issue(OP_GR_SPILL_STORE, 7'd0, 7'd11, 64'h3f8, 2'h0, 1'b0);
        chk({resp.mem_bytes, resp.reg_no}, {4'h8, 7'd11});
        rdr(8'h00);
        chk(rd, 64'h8000_0000_0000_0000);
        wr(8'h00, 64'h0);
        issue(OP_GR_FILL_LOAD, 7'd13, 7'd0, 64'h028, 2'h0, 1'b0);
        chk({resp.mem_bytes, token}, {4'h8, 1'b0});
        wr(8'h00, 64'h20);
        issue(OP_GR_FILL_LOAD, 7'd13, 7'd0, 64'h228, 2'h0, 1'b0);
        chk(token, 1'b1);
        // Floating registers carry the special value
        issue(OP_FP_SPEC_LOAD, 7'd30, 7'd0, 64'h80, 2'h0, 1'b1);
        chk({resp.fp_token_we, fp_wdata}, {1'b1, FP_TOK});
        issue(OP_FP_SPILL, 7'd0, 7'd30, 64'h90, 2'h0, 1'b0);
        rsp(4'b1000);
        issue(OP_FP_FILL, 7'd30, 7'd0, 64'h90, 2'h0, 1'b0);
        rsp(4'b1000);
        give_verdict();
    end

endmodule // load_spec_tracker_test
`default_nettype wire
